// file: rtl/spims_regs.svh
// register offsets, field positions, reset values and rate counts of the spi port
// assumes a byte-addressed avalon-mm slave with one 32-bit word per register
`ifndef SPIMS_REGS_SVH
`define SPIMS_REGS_SVH

// ****************************************
// register byte addresses
// ****************************************
`define SPIMS_ADDR_CTRL   4'h0
`define SPIMS_ADDR_STAT   4'h4
`define SPIMS_ADDR_DATA   4'h8

// ****************************************
// control fields
// ****************************************
`define SPIMS_CTL_IRQEN   7
`define SPIMS_CTL_PEN     6
`define SPIMS_CTL_LSB     5
`define SPIMS_CTL_MASTER_ROLE_SELECT    4
`define SPIMS_CTL_CLOCK_IDLE_POLARITY    3
`define SPIMS_CTL_CLOCK_SAMPLE_PHASE    2
`define SPIMS_CTL_RHI     1
`define SPIMS_CTL_RLO     0

// ****************************************
// status fields
// ****************************************
`define SPIMS_STAT_DONE   7
`define SPIMS_STAT_COLL   6
`define SPIMS_STAT_DBL    0

// ****************************************
// reset values
// ****************************************
`define SPIMS_CTRL_RESET  8'h00
`define SPIMS_STAT_RESET  8'h00
`define SPIMS_DATA_RESET  8'h00

// ****************************************
// sck half periods in system clocks
// ****************************************
`define SPIMS_HALF_DIV4   7'h02
`define SPIMS_HALF_DIV16  7'h08
`define SPIMS_HALF_DIV64  7'h20
`define SPIMS_HALF_DIV128 7'h40
`define SPIMS_HALF_DIV2   7'h01
`define SPIMS_HALF_DIV8   7'h04
`define SPIMS_HALF_DIV32  7'h10

// ****************************************
// byte framing
// ****************************************
`define SPIMS_LAST_BIT    4'h7
`define SPIMS_LAST_EDGE   5'h0F

`endif

// file: rtl/spims_pkg.sv
// types shared by the spi port modules
// assumes nothing beyond a systemverilog-2012 compiler
package spims_pkg;

   // ****************************************
   // pin groups
   // ****************************************
   typedef struct packed
   {
      logic sck;
      logic mosi;
      logic miso;
      logic ssN;
   } spims_pin_in_t;

   typedef struct packed
   {
      logic sck;
      logic sckOeN;
      logic mosi;
      logic mosiOeN;
      logic miso;
      logic misoOeN;
   } spims_pin_out_t;

   // ****************************************
   // transfer engine states
   // ****************************************
   typedef enum logic [2:0]
   {
      SPIMS_IDLE = 3'b001,
      SPIMS_MRUN = 3'b010,
      SPIMS_SRUN = 3'b100
   } spims_state_t;

endpackage

// file: rtl/spims_rate_gen.sv
// master sck half-period tick generator
// assumes run stays high for the whole master byte
`timescale 1ns/1ps
`include "spims_regs.svh"

module spims_rate_gen import spims_pkg::*;
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       reset,
   input  wire logic       clockEnable,
   // control
   input  wire logic       run,
   input  wire logic [2:0] rateSel,
   // tick
   output wire logic       tick
);

   logic [6:0] cntReg;
   logic       tickReg;
   logic [6:0] halfSel;
   wire  [6:0] reload = halfSel - 7'h01;

   // ****************************************
   // rate table
   // ****************************************
   always_comb
   begin
      case (rateSel)
         3'h0:    halfSel = `SPIMS_HALF_DIV4;
         3'h1:    halfSel = `SPIMS_HALF_DIV16;
         3'h2:    halfSel = `SPIMS_HALF_DIV64;
         3'h3:    halfSel = `SPIMS_HALF_DIV128;
         3'h4:    halfSel = `SPIMS_HALF_DIV2;
         3'h5:    halfSel = `SPIMS_HALF_DIV8;
         3'h6:    halfSel = `SPIMS_HALF_DIV32;
         default: halfSel = `SPIMS_HALF_DIV64;
      endcase
   end

   // ****************************************
   // down counter
   // ****************************************
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         cntReg  <= 7'h00;
         tickReg <= 1'b0;
      end
      else if (clockEnable)
      begin
         if (!run || cntReg == 7'h00)
            cntReg <= reload;
         else
            cntReg <= cntReg - 7'h01;
         tickReg <= run && cntReg == 7'h00;
      end
   end

   // tick left over from the last running cycle masked once run drops
   assign tick = tickReg & run;

endmodule

// file: rtl/spims_sck_edge.sv
// slave-side sck edge detector
// assumes sck is synchronous to clock and each level lasts over 2 clocks
`timescale 1ns/1ps

module spims_sck_edge import spims_pkg::*;
(
   // clock and reset
   input  wire logic clock,
   input  wire logic reset,
   input  wire logic clockEnable,
   // pin
   input  wire logic sckIn,
   // edges
   output wire logic sckRise,
   output wire logic sckFall
);

   logic sckNowReg;
   logic sckPrevReg;

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         sckNowReg  <= 1'b0;
         sckPrevReg <= 1'b0;
      end
      else if (clockEnable)
      begin
         sckNowReg  <= sckIn;
         sckPrevReg <= sckNowReg;
      end
   end

   assign sckRise = sckNowReg & ~sckPrevReg;
   assign sckFall = ~sckNowReg & sckPrevReg;

endmodule

// file: rtl/spims_port.sv
// byte-oriented spi port, master or slave, with avalon-mm register access
// assumes pins synchronous to clock and an outside agent resolving the tri-states
//
// Local design decisions: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "spims_regs.svh"

// Operation
// - drive on one edge, sample on other
// - polarity one idles high, zero idles low
// - phase zero samples leading, one samples trailing
// - bit order one sends lsb first
// - nothing happens unless port enabled
// - role bit one master, zero slave
// - select low as input drops master role
// - rate bits and double speed pick divider
// - rate bits ignored in slave role
// - double speed halves master sck period
// - byte finished sets transfer done flag
// - interrupt when flag, enable, global enable
// - vector taken clears transfer done flag
// - status read then data access clears done
// - data write while busy sets collision
// - collision seen then data access clears both
// - status bits five to one read zero
// - data write loads shifter and starts
// - data read returns receive buffer
// - receive buffer overwritten by next byte
// - slave select high resets shift logic
module spims_port import spims_pkg::*;
(
   // clock and reset
   input  wire logic           clock,
   input  wire logic           reset,
   input  wire logic           clockEnable,
   // avalon-mm slave
   input  wire logic [3:0]     address,
   input  wire logic           read,
   input  wire logic           write,
   input  wire logic [3:0]     byteenable,
   input  wire logic [31:0]    writedata,
   output logic      [31:0]    readdata,
   output logic                waitrequest,
   // cpu side
   input  wire logic           globalIrqEnable,
   input  wire logic           irqVectorTaken,
   input  wire logic           ssPinInput,
   output logic                irqRequest,
   // serial pins
   input  wire spims_pin_in_t  pinIn,
   output spims_pin_out_t      pinOut
);

   // ****************************************
   // state
   // ****************************************
   logic [7:0]     ctrlReg;
   logic           dblReg;
   logic           doneReg;
   logic           collReg;
   logic           seenDoneReg;
   logic           seenCollReg;
   logic [7:0]     rxBufReg;
   logic [7:0]     rxShReg;
   logic [7:0]     txShReg;
   logic [3:0]     bitCntReg;
   logic [4:0]     edgeCntReg;
   spims_state_t   stateReg;
   spims_state_t   stateNext;

   // ****************************************
   // bus decode
   // ****************************************
   wire busReq   = read | write;
   wire accept   = busReq & ~waitrequest;
   wire selCtrl  = address == `SPIMS_ADDR_CTRL;
   wire selStat  = address == `SPIMS_ADDR_STAT;
   wire selData  = address == `SPIMS_ADDR_DATA;
   wire lowLane  = byteenable[0];
   wire ctrlWr   = accept & write & lowLane & selCtrl;
   wire statWr   = accept & write & lowLane & selStat;
   wire dataWr   = accept & write & lowLane & selData;
   wire statRd   = accept & read & selStat;
   wire dataAcc  = accept & selData;

   // ****************************************
   // control fields
   // ****************************************
   wire portEn   = ctrlReg[`SPIMS_CTL_PEN];
   wire isMaster = ctrlReg[`SPIMS_CTL_MASTER_ROLE_SELECT];
   wire clock_idle_polarity     = ctrlReg[`SPIMS_CTL_CLOCK_IDLE_POLARITY];
   wire clock_sample_phase     = ctrlReg[`SPIMS_CTL_CLOCK_SAMPLE_PHASE];
   wire lsbFirst = ctrlReg[`SPIMS_CTL_LSB];
   wire irqEn    = ctrlReg[`SPIMS_CTL_IRQEN];

   // ****************************************
   // role and select
   // ****************************************
   wire modeFault = portEn & isMaster & ssPinInput & ~pinIn.ssN;
   wire slaveSel  = portEn & ~isMaster & ~pinIn.ssN;
   wire mRun      = stateReg == SPIMS_MRUN;
   wire sRun      = (stateReg == SPIMS_SRUN) & slaveSel;
   wire busy      = mRun | (sRun & bitCntReg != 4'h0);

   // ****************************************
   // master rate generator
   // ****************************************
   wire       tick;
   wire [2:0] rateSel = {dblReg, ctrlReg[`SPIMS_CTL_RHI], ctrlReg[`SPIMS_CTL_RLO]};

   // only runs in master state, so slave timing never sees the rate bits
   spims_rate_gen uRate
   (
      .clock       (clock),
      .clockEnable (clockEnable),
      .reset       (reset),
      .run         (mRun),
      .rateSel     (rateSel),
      .tick        (tick)
   );

   // ****************************************
   // slave sck edges
   // ****************************************
   wire sckRise;
   wire sckFall;

   // two clocks per sck level are needed here, hence the outside limit
   spims_sck_edge uEdge
   (
      .clock       (clock),
      .reset       (reset),
      .clockEnable (clockEnable),
      .sckIn       (pinIn.sck),
      .sckRise     (sckRise),
      .sckFall     (sckFall)
   );

   // ****************************************
   // edge roles
   // ****************************************
   wire sLead   = sRun & (clock_idle_polarity ? sckFall : sckRise);
   wire sTrail  = sRun & (clock_idle_polarity ? sckRise : sckFall);
   wire mLead   = mRun & tick & ~edgeCntReg[0];
   wire mTrail  = mRun & tick & edgeCntReg[0];
   wire leadE   = mLead | sLead;
   wire trailE  = mTrail | sTrail;
   wire sampleE = clock_sample_phase ? trailE : leadE;
   wire setupE  = clock_sample_phase ? leadE : trailE;
   wire mEnd    = mRun & tick & edgeCntReg == `SPIMS_LAST_EDGE;
   wire lastBit = bitCntReg == `SPIMS_LAST_BIT;
   wire byteIn  = sampleE & lastBit;

   // ****************************************
   // shift data paths
   // ****************************************
   wire       inBit   = mRun ? pinIn.miso : pinIn.mosi;
   wire [7:0] rxShIn  = lsbFirst ? {inBit, rxShReg[7:1]} : {rxShReg[6:0], inBit};
   wire       loadTx  = dataWr & ~busy;
   // no shift before the first sample, so the first bit stays on the pin
   wire       shiftTx = setupE & bitCntReg != 4'h0;
   wire [7:0] txShOut = lsbFirst ? {1'b0, txShReg[7:1]} : {txShReg[6:0], 1'b0};
   wire [7:0] txShNext = loadTx ? writedata[7:0] : (shiftTx ? txShOut : txShReg);
   wire       serOut  = lsbFirst ? txShNext[0] : txShNext[7];

   // ****************************************
   // flag events
   // ****************************************
   wire doneSet  = mEnd | (sRun & byteIn) | modeFault;
   wire collSet  = dataWr & busy;
   wire collClr  = dataAcc & seenCollReg;
   wire doneClr  = (dataAcc & (seenDoneReg | seenCollReg)) | irqVectorTaken;
   wire doneNext = doneSet | (doneReg & ~doneClr);
   wire collNext = collSet | (collReg & ~collClr);

   // ****************************************
   // read mux
   // ****************************************
   wire [7:0] statView = {doneReg, collReg, 5'h00, dblReg};
   wire [7:0] rdByte   = selCtrl ? ctrlReg :
                         selStat ? statView :
                         selData ? rxBufReg : 8'h00;

   // ****************************************
   // control register
   // ****************************************
   wire [7:0] ctrlWrVal = ctrlWr ? writedata[7:0] : ctrlReg;
   // fault wins over a simultaneous write that sets the role bit
   wire [7:0] ctrlNext  = modeFault ? (ctrlWrVal & ~(8'h01 << `SPIMS_CTL_MASTER_ROLE_SELECT)) : ctrlWrVal;

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         ctrlReg <= `SPIMS_CTRL_RESET;
         dblReg  <= 1'b0;
      end
      else if (clockEnable)
      begin
         ctrlReg <= ctrlNext;
         if (statWr)
            dblReg <= writedata[`SPIMS_STAT_DBL];
      end
   end

   // ****************************************
   // status flags
   // ****************************************
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         doneReg     <= 1'b0;
         collReg     <= 1'b0;
         seenDoneReg <= 1'b0;
         seenCollReg <= 1'b0;
      end
      else if (clockEnable)
      begin
         doneReg <= doneNext;
         collReg <= collNext;
         if (statRd)
         begin
            seenDoneReg <= doneReg;
            seenCollReg <= collReg;
         end
         else if (dataAcc)
         begin
            seenDoneReg <= 1'b0;
            seenCollReg <= 1'b0;
         end
      end
   end

   // ****************************************
   // engine state
   // ****************************************
   always_comb
   begin
      case (stateReg)
         SPIMS_IDLE:
            if (portEn && isMaster && loadTx && !modeFault)
               stateNext = SPIMS_MRUN;
            else if (slaveSel)
               stateNext = SPIMS_SRUN;
            else
               stateNext = SPIMS_IDLE;
         SPIMS_MRUN:
            if (mEnd || modeFault || !portEn || !isMaster)
               stateNext = SPIMS_IDLE;
            else
               stateNext = SPIMS_MRUN;
         SPIMS_SRUN:
            if (!slaveSel)
               stateNext = SPIMS_IDLE;
            else
               stateNext = SPIMS_SRUN;
         default:
            stateNext = SPIMS_IDLE;
      endcase
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         stateReg <= SPIMS_IDLE;
      else if (clockEnable)
         stateReg <= stateNext;
   end

   // ****************************************
   // shift registers and counters
   // ****************************************
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         txShReg    <= `SPIMS_DATA_RESET;
         rxShReg    <= `SPIMS_DATA_RESET;
         rxBufReg   <= `SPIMS_DATA_RESET;
         bitCntReg  <= 4'h0;
         edgeCntReg <= 5'h00;
      end
      else if (clockEnable)
      begin
         txShReg <= txShNext;
         if (!mRun && !sRun)
         begin
            // partial bits dropped whenever the engine goes quiet
            bitCntReg  <= 4'h0;
            rxShReg    <= 8'h00;
            edgeCntReg <= 5'h00;
         end
         else
         begin
            if (sampleE)
            begin
               rxShReg   <= rxShIn;
               bitCntReg <= lastBit ? 4'h0 : bitCntReg + 4'h1;
            end
            if (mRun && tick)
               edgeCntReg <= edgeCntReg + 5'h01;
         end
         // single buffer; an unread byte is simply overwritten
         if (byteIn)
            rxBufReg <= rxShIn;
      end
   end

   // ****************************************
   // avalon handshake
   // ****************************************
   // one wait cycle per access so the read word can come from a flop
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         waitrequest <= 1'b1;
         readdata    <= 32'h0000_0000;
      end
      else if (clockEnable)
      begin
         if (busReq && waitrequest)
         begin
            waitrequest <= 1'b0;
            readdata    <= {24'h00_0000, rdByte};
         end
         else
            waitrequest <= 1'b1;
      end
   end

   // ****************************************
   // interrupt and pins
   // ****************************************
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         irqRequest     <= 1'b0;
         pinOut.sck     <= 1'b0;
         pinOut.sckOeN  <= 1'b1;
         pinOut.mosi    <= 1'b0;
         pinOut.mosiOeN <= 1'b1;
         pinOut.miso    <= 1'b0;
         pinOut.misoOeN <= 1'b1;
      end
      else if (clockEnable)
      begin
         irqRequest <= doneNext & irqEn & globalIrqEnable;
         if (mRun && stateNext == SPIMS_MRUN)
            pinOut.sck <= tick ? ~pinOut.sck : pinOut.sck;
         else
            pinOut.sck <= clock_idle_polarity;
         pinOut.sckOeN  <= ~(portEn & isMaster & ~modeFault);
         pinOut.mosiOeN <= ~(portEn & isMaster & ~modeFault);
         pinOut.misoOeN <= ~(slaveSel & ~isMaster);
         pinOut.mosi    <= serOut;
         pinOut.miso    <= serOut;
      end
   end

endmodule

// file: tb/spims_port_sva.sv
// checker for the spi port: bus handshake, pin roles and interrupt line
// assumes it is bound into spims_port and sees only its ports
`timescale 1ns/1ps
`include "spims_regs.svh"

module spims_port_sva import spims_pkg::*;
(
   // clock and reset
   input wire logic           clock,
   input wire logic           reset,
   // bus
   input wire logic [3:0]     address,
   input wire logic           read,
   input wire logic           write,
   input wire logic [31:0]    readdata,
   input wire logic           waitrequest,
   // cpu side
   input wire logic           globalIrqEnable,
   input wire logic           irqVectorTaken,
   input wire logic           ssPinInput,
   input wire logic           irqRequest,
   // pins
   input wire spims_pin_in_t  pinIn,
   input wire spims_pin_out_t pinOut
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   // ****************************************
   // properties
   // ****************************************
   property p_handshake; (read || write) && waitrequest |=> !waitrequest ##1 waitrequest; endproperty
   a_handshake: assert property (p_handshake) else $error("wait state not one cycle");
   property p_status_rsvd; read && !waitrequest && address == `SPIMS_ADDR_STAT |-> readdata[5:1] == 5'h00; endproperty
   a_status_rsvd: assert property (p_status_rsvd) else $error("reserved status bits set");
   property p_irq_gated; !globalIrqEnable |=> !irqRequest; endproperty
   a_irq_gated: assert property (p_irq_gated) else $error("irq without global enable");
   property p_vector_clear; irqVectorTaken |-> ##2 !irqRequest; endproperty
   a_vector_clear: assert property (p_vector_clear) else $error("irq stays after vector");
   property p_master_pins; pinOut.sckOeN == pinOut.mosiOeN; endproperty
   a_master_pins: assert property (p_master_pins) else $error("sck and mosi drive differ");
   property p_one_role; !pinOut.misoOeN |-> pinOut.sckOeN; endproperty
   a_one_role: assert property (p_one_role) else $error("master and slave drive at once");
   property p_fault_drop; ssPinInput && !pinIn.ssN && !pinOut.sckOeN |-> ##[1:3] pinOut.sckOeN; endproperty
   a_fault_drop: assert property (p_fault_drop) else $error("master kept after select low");
   property p_slave_quiet; pinIn.ssN [*2] |-> pinOut.misoOeN; endproperty
   a_slave_quiet: assert property (p_slave_quiet) else $error("miso driven while deselected");
   c_fault: cover property (ssPinInput && !pinIn.ssN && !pinOut.sckOeN);
   c_irq: cover property ($rose(irqRequest));
   c_vector: cover property (irqVectorTaken && irqRequest);
endmodule

bind spims_port spims_port_sva u_sva (.clock(clock), .reset(reset), .address(address), .read(read),
   .write(write), .readdata(readdata), .waitrequest(waitrequest), .globalIrqEnable(globalIrqEnable),
   .irqVectorTaken(irqVectorTaken), .ssPinInput(ssPinInput), .irqRequest(irqRequest), .pinIn(pinIn),
   .pinOut(pinOut));

// file: tb/spims_partner.sv
// outside spi slave answering the port in master role
// assumes sck and mosi are the resolved pin levels and select comes from the bench
`timescale 1ns/1ps

module spims_partner
(
   // clock
   input  wire logic       clock,
   // serial pins
   input  wire logic       sck,
   input  wire logic       mosi,
   input  wire logic       ssN,
   output wire logic       miso,
   // mode and data
   input  wire logic       clock_idle_polarity,
   input  wire logic       clock_sample_phase,
   input  wire logic       lsbFirst,
   input  wire logic [7:0] txByte,
   output logic      [7:0] rxByte = 8'h00
);
   logic [3:0] setups = 4'h0;
   logic       lastSck = 1'b0;
   logic       junk = 1'b0;
   wire  [2:0] bitIdx = setups[2:0] - {2'h0, clock_sample_phase};
   wire  [2:0] outIdx = lsbFirst ? bitIdx : 3'h7 - bitIdx;

   // deselected line wanders so a stale bit never passes as data
   assign miso = ssN ? junk : txByte[outIdx];
   always @(posedge clock) junk <= ~junk;

   // reacts in the edge's own time step, as a real slave output would
   always @(sck or ssN)
   begin
      if (ssN)
         setups = 4'h0;
      else if (sck !== lastSck)
      begin
         if ((sck != clock_idle_polarity) == clock_sample_phase)
            setups = setups + 4'h1;
         else
            rxByte = lsbFirst ? {mosi, rxByte[7:1]} : {rxByte[6:0], mosi};
      end
      lastSck = sck;
   end
endmodule

// file: tb/testbench.sv
// self-checking bench for the spi port in master role against a slave model, and in slave role with sck driven by the bench
// assumes spims_port, spims_partner and the bound checker are compiled first
`timescale 1ns/1ps
`include "spims_regs.svh"

module testbench import spims_pkg::*;;
   logic           clock = 1'b0;
   logic           reset = 1'b1;
   logic [3:0]     address = 4'h0;
   logic           read = 1'b0;
   logic           write = 1'b0;
   logic [31:0]    writedata = 32'h0;
   wire  [31:0]    readdata;
   wire            waitrequest;
   logic           globalIrqEnable = 1'b0;
   logic           irqVectorTaken = 1'b0;
   logic           ssPinInput = 1'b0;
   wire            irqRequest;
   logic           ssN = 1'b1;
   logic [7:0]     ctlSet = 8'h00;
   logic [7:0]     peerTx = 8'h00;
   wire  [7:0]     peerRx;
   wire            peerMiso;
   wire spims_pin_in_t pinIn;
   spims_pin_out_t pinOut;
   int             failures = 0;
   int             check_count = 0;
   int             cycles = 0;
   int             gap = 0;
   int             lastGap = 0;
   logic           sckQ = 1'b0;

   // released pins: sck rests at polarity, mosi shows a changing level
   assign pinIn = {pinOut.sckOeN ? ctlSet[3] : pinOut.sck, pinOut.mosiOeN ? ~pinOut.mosi : pinOut.mosi,
                   pinOut.misoOeN ? peerMiso : pinOut.miso, ssN};

   spims_port u_dut (.clock(clock), .reset(reset), .clockEnable(1'b1), .address(address), .read(read),
      .write(write), .byteenable(4'hF), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .globalIrqEnable(globalIrqEnable), .irqVectorTaken(irqVectorTaken), .ssPinInput(ssPinInput),
      .irqRequest(irqRequest), .pinIn(pinIn), .pinOut(pinOut));
   spims_partner u_peer (.clock(clock), .sck(pinIn.sck), .mosi(pinIn.mosi), .ssN(ssN), .miso(peerMiso),
      .clock_idle_polarity(ctlSet[3]), .clock_sample_phase(ctlSet[2]), .lsbFirst(ctlSet[5]), .txByte(peerTx), .rxByte(peerRx));

   always #5 clock = ~clock;

   always @(posedge clock)
   begin
      sckQ <= pinOut.sck;
      gap <= (pinOut.sck != sckQ) ? 1 : gap + 1;
      if (pinOut.sck != sckQ)
         lastGap <= gap;
      cycles <= cycles + 1;
      if (cycles == 40000)
      begin
         failures = failures + 1;
         test_done();
      end
   end

   // ****************************************
   // tasks
   // ****************************************
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] expVal, input logic [31:0] gotVal);
      check_count++;
      if (gotVal !== expVal)
      begin
         failures++;
         $display("BAD %s expected %h seen %h", what, expVal, gotVal);
      end
   endtask

   task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q);
      @(posedge clock);
      address <= a;
      writedata <= {24'h0, d};
      write <= wr;
      read <= ~wr;
      do
      begin
         @(posedge clock);
      end
      while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rdchk(input logic [3:0] a, input logic [31:0] e, input string nm);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(nm, e, q);
   endtask

   task automatic wait_done(output logic [31:0] q);
      int n;
      n = 0;
      do
      begin
         bus(1'b0, `SPIMS_ADDR_STAT, 8'h00, q);
         n++;
      end
      while (q[7] !== 1'b1 && n < 3000);
   endtask

   task automatic start(input logic [7:0] ctl, input logic [7:0] tx, input logic [7:0] rx);
      ctlSet <= ctl;
      wr(`SPIMS_ADDR_CTRL, ctl);
      peerTx <= rx;
      wr(`SPIMS_ADDR_DATA, tx);
      ssN <= 1'b0;
   endtask

   task automatic test_regs();
      rdchk(`SPIMS_ADDR_CTRL, 32'h00, "control reset");
      rdchk(`SPIMS_ADDR_STAT, 32'h00, "status reset");
      rdchk(4'hC, 32'h00, "unmapped read");
      wr(`SPIMS_ADDR_STAT, 8'hFF);
      wr(4'hC, 8'h5A);
      rdchk(`SPIMS_ADDR_STAT, 32'h01, "status write mask");
      wr(`SPIMS_ADDR_CTRL, 8'hAF);
      rdchk(`SPIMS_ADDR_CTRL, 32'hAF, "control write");
      wr(`SPIMS_ADDR_CTRL, 8'h00);
   endtask

   task automatic test_modes();
      int halves[8] = '{2, 8, 32, 64, 1, 4, 16, 32};
      logic [31:0] q;
      logic [7:0] tx;
      logic [7:0] rx;
      for (int i = 0; i < 8; i++)
      begin
         tx = 8'h1D + {5'h00, i[2:0]};
         rx = 8'hC2 ^ {5'h00, i[2:0]};
         wr(`SPIMS_ADDR_STAT, {7'h00, i[2]});
         start({1'b0, 1'b1, i[2], 1'b1, i[1], i[0], i[1], i[0]}, tx, rx);
         wait_done(q);
         chk("done flag", 32'h1, {31'h0, q[7]});
         chk("peer byte", {24'h0, tx}, {24'h0, peerRx});
         chk("sck half period", halves[i], lastGap);
         chk("sck idle", {31'h0, i[1]}, {31'h0, pinOut.sck});
         rdchk(`SPIMS_ADDR_DATA, {24'h0, rx}, "receive data");
         rdchk(`SPIMS_ADDR_STAT, {31'h0, i[2]}, "flags cleared");
         ssN <= 1'b1;
      end
   endtask

   task automatic test_collision();
      logic [31:0] q;
      wr(`SPIMS_ADDR_STAT, 8'h00);
      start(8'h53, 8'h96, 8'h3C);
      wr(`SPIMS_ADDR_DATA, 8'h69);
      rdchk(`SPIMS_ADDR_STAT, 32'h40, "collision flag");
      wait_done(q);
      chk("both flags", 32'hC0, q);
      rdchk(`SPIMS_ADDR_DATA, 32'h3C, "data after collision");
      rdchk(`SPIMS_ADDR_STAT, 32'h00, "flags after clear");
      chk("first byte kept", 32'h96, {24'h0, peerRx});
      ssN <= 1'b1;
   endtask

   task automatic test_disabled();
      start(8'h10, 8'hA5, 8'h00);
      repeat (200) @(posedge clock);
      rdchk(`SPIMS_ADDR_STAT, 32'h00, "no transfer when off");
      chk("sck released when off", 32'h1, {31'h0, pinOut.sckOeN});
      ssN <= 1'b1;
   endtask

   task automatic test_slave();
      wr(`SPIMS_ADDR_CTRL, 8'h40);
      ssN <= 1'b0;
      repeat (16)
      begin
         repeat (3) @(posedge clock);
         ctlSet[3] <= ~ctlSet[3];
      end
      rdchk(`SPIMS_ADDR_STAT, 32'h80, "slave byte done");
      ssN <= 1'b1;
   endtask

   task automatic test_fault();
      ctlSet <= 8'hD0;
      wr(`SPIMS_ADDR_CTRL, 8'hD0);
      @(posedge clock);
      ssPinInput <= 1'b1;
      ssN <= 1'b0;
      repeat (4) @(posedge clock);
      rdchk(`SPIMS_ADDR_CTRL, 32'hC0, "role dropped");
      globalIrqEnable <= 1'b1;
      repeat (3) @(posedge clock);
      chk("irq raised", 32'h1, {31'h0, irqRequest});
      globalIrqEnable <= 1'b0;
      repeat (3) @(posedge clock);
      chk("irq masked", 32'h0, {31'h0, irqRequest});
      ssPinInput <= 1'b0;
      ssN <= 1'b1;
      globalIrqEnable <= 1'b1;
      irqVectorTaken <= 1'b1;
      @(posedge clock);
      irqVectorTaken <= 1'b0;
      repeat (3) @(posedge clock);
      chk("irq after vector", 32'h0, {31'h0, irqRequest});
      rdchk(`SPIMS_ADDR_STAT, 32'h00, "done after vector");
   endtask

   initial
   begin
      repeat (16) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      test_regs();
      test_modes();
      test_collision();
      test_disabled();
      test_slave();
      test_fault();
      test_done();
   end
endmodule
